// >>> hdl/pst_pkg.sv
package pst_pkg;
    // display codes handed to the display driver
    localparam logic [2:0] DISP_BLANK = 3'h0;
    localparam logic [2:0] DISP_ZEROS = 3'h1;
    localparam logic [2:0] DISP_AAAA = 3'h2;
    localparam logic [2:0] DISP_UNCALIBRATED_MESSAGE = 3'h3;
    localparam logic [2:0] DISP_ADDR_REV = 3'h4;
    localparam logic [2:0] DISP_SEGTEST = 3'h5;
    localparam logic [2:0] DISP_STEP = 3'h6;
    localparam logic [2:0] DISP_NORMAL = 3'h7;
    // diagnostic program number, two decimal digits
    localparam logic [3:0] DIAG_DIGIT_HI = 4'h3;
    localparam logic [3:0] DIAG_DIGIT_LO = 4'h3;
    // troubleshooting steps 01..04
    localparam logic [2:0] STEP_FIRST = 3'h1;
    localparam logic [2:0] STEP_LAST = 3'h4;
    localparam int SEG_COUNT = 8;
    localparam logic [2:0] SEG_LAST = 3'h7;
    // segment dwell and address/revision hold, in microseconds
    localparam int SEG_DWELL_US = 200000;
    localparam int INFO_HOLD_US = 1000000;
    localparam int CLK_MHZ = 250;
    localparam int SEG_DWELL_CYC = SEG_DWELL_US * CLK_MHZ;
    localparam int INFO_HOLD_CYC = INFO_HOLD_US * CLK_MHZ;
    localparam int TMR_W = 28;

    typedef enum logic [1:0] {PST_MEM_ROM, PST_MEM_RAM, PST_MEM_NVM} pst_mem_e;
endpackage

// >>> hdl/pst_sync.sv
module pst_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pst_sync

// >>> hdl/pst_top.sv
// Functional notes
// - at power up check program memory first; fail halts showing all zeros
// - after program memory passes test RAM; fail halts showing all A
// - then check calibration store; failure shows uncalibrated message, no halt
// - while uncalibrated message shown, any momentary button resumes normal operation
// - all memory tests pass: show bus address and firmware revision
// - after self test, enter default power-up measurement function; code pulses it only after all three tests pass
// - diagnostics first step segments through display with all LEDs on
// - after display test repeat the three memory tests, same outcomes
// - then troubleshooting mode starts at step 01, step shown on display
// - troubleshooting keeps function and range selected before diagnostics
// - each step drives that step's switch and relay controls for function/range; code only outputs step_out
// - each enter press advances to the next troubleshooting step
// - any other momentary button ends diagnostics, restores normal operation
module pst_top #(
    parameter int SEG_DWELL = pst_pkg::SEG_DWELL_CYC,
    parameter int INFO_HOLD = pst_pkg::INFO_HOLD_CYC
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic mem_done_in,
    input wire logic mem_pass_in,
    input wire logic program_select_button_in,
    input wire logic enter_button_in,
    input wire logic other_button_in,
    input wire logic [3:0] digit_in,
    input wire logic digit_valid_in,
    input wire logic [3:0] function_in,
    input wire logic [2:0] range_in,
    output logic mem_start_out,
    output logic [1:0] mem_sel_out,
    output logic [2:0] disp_code_out,
    output logic [2:0] disp_seg_out,
    output logic [2:0] step_out,
    output logic leds_all_on_out,
    output logic diag_active_out,
    output logic default_function_out,
    output logic [3:0] trace_function_out,
    output logic [2:0] trace_range_out,
    output logic halted_out
);
    typedef enum logic [3:0] {
        ST_MEM_GO, ST_MEM_WAIT, ST_HALT, ST_UNCALIBRATED_MESSAGE, ST_INFO, ST_NORMAL,
        ST_PGM_HI, ST_PGM_LO, ST_SEG, ST_TROUBLE
    } pst_state_e;

    logic [2:0] btn_s;
    logic [3:0] dig_s;
    logic dv_s;
    logic [2:0] btn_d_r;
    logic dv_d_r;
    logic pgm_p, ent_p, oth_p, dig_p;
    logic done_s, pass_s, done_d_r, done_p;
    pst_state_e state_r;
    logic diag_r;
    logic [pst_pkg::TMR_W-1:0] tmr_r;
    logic [2:0] seg_r;

    // done and result share one synchroniser so they stay aligned
    pst_sync #(.W(5)) u_sync_btn (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({mem_done_in, mem_pass_in, program_select_button_in, enter_button_in,
                   other_button_in}),
        .sync_out({done_s, pass_s, btn_s})
    );
    pst_sync #(.W(5)) u_sync_dig (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({digit_valid_in, digit_in}),
        .sync_out({dv_s, dig_s})
    );

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            btn_d_r <= '0;
            dv_d_r <= 1'b0;
            done_d_r <= 1'b0;
        end
        else
        begin
            btn_d_r <= btn_s;
            dv_d_r <= dv_s;
            done_d_r <= done_s;
        end
    end

    assign pgm_p = btn_s[2] & ~btn_d_r[2];
    assign ent_p = btn_s[1] & ~btn_d_r[1];
    assign oth_p = btn_s[0] & ~btn_d_r[0];
    assign dig_p = dv_s & ~dv_d_r;
    assign done_p = done_s & ~done_d_r;

    // sequencer
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_r <= ST_MEM_GO;
            diag_r <= 1'b0;
            tmr_r <= '0;
            seg_r <= '0;
            mem_sel_out <= pst_pkg::PST_MEM_ROM;
            mem_start_out <= 1'b0;
            step_out <= pst_pkg::STEP_FIRST;
            halted_out <= 1'b0;
        end
        else
        begin
            mem_start_out <= 1'b0;
            case (state_r)
                ST_MEM_GO:
                begin
                    mem_start_out <= 1'b1;
                    state_r <= ST_MEM_WAIT;
                end
                ST_MEM_WAIT:
                begin
                    if (done_p)
                    begin
                        if (mem_sel_out == pst_pkg::PST_MEM_NVM)
                        begin
                            tmr_r <= '0;
                            state_r <= pass_s ? ST_INFO : ST_UNCALIBRATED_MESSAGE;
                        end
                        else if (!pass_s)
                        begin
                            halted_out <= 1'b1;
                            state_r <= ST_HALT;
                        end
                        else
                        begin
                            mem_sel_out <= (mem_sel_out == pst_pkg::PST_MEM_ROM) ?
                                pst_pkg::PST_MEM_RAM : pst_pkg::PST_MEM_NVM;
                            state_r <= ST_MEM_GO;
                        end
                    end
                end
                ST_HALT:
                    state_r <= ST_HALT;
                ST_UNCALIBRATED_MESSAGE:
                begin
                    if (pgm_p || ent_p || oth_p)
                    begin
                        state_r <= ST_NORMAL;
                        diag_r <= 1'b0;
                    end
                end
                ST_INFO:
                begin
                    tmr_r <= tmr_r + 1'b1;
                    if (tmr_r == pst_pkg::TMR_W'(INFO_HOLD - 1))
                    begin
                        step_out <= pst_pkg::STEP_FIRST;
                        state_r <= diag_r ? ST_TROUBLE : ST_NORMAL;
                    end
                end
                ST_NORMAL:
                    if (pgm_p)
                        state_r <= ST_PGM_HI;
                ST_PGM_HI:
                begin
                    if (oth_p || ent_p)
                        state_r <= ST_NORMAL;
                    else if (dig_p)
                        state_r <= (dig_s == pst_pkg::DIAG_DIGIT_HI) ? ST_PGM_LO : ST_NORMAL;
                end
                ST_PGM_LO:
                begin
                    if (oth_p || ent_p)
                        state_r <= ST_NORMAL;
                    else if (dig_p)
                    begin
                        if (dig_s == pst_pkg::DIAG_DIGIT_LO)
                        begin
                            diag_r <= 1'b1;
                            tmr_r <= '0;
                            seg_r <= '0;
                            state_r <= ST_SEG;
                        end
                        else
                            state_r <= ST_NORMAL;
                    end
                end
                ST_SEG:
                begin
                    tmr_r <= tmr_r + 1'b1;
                    if (tmr_r == pst_pkg::TMR_W'(SEG_DWELL - 1))
                    begin
                        tmr_r <= '0;
                        seg_r <= seg_r + 1'b1;
                        if (seg_r == pst_pkg::SEG_LAST)
                        begin
                            mem_sel_out <= pst_pkg::PST_MEM_ROM;
                            state_r <= ST_MEM_GO;
                        end
                    end
                end
                ST_TROUBLE:
                begin
                    if (oth_p || pgm_p)
                    begin
                        diag_r <= 1'b0;
                        state_r <= ST_NORMAL;
                    end
                    else if (ent_p)
                        step_out <= (step_out == pst_pkg::STEP_LAST) ?
                            pst_pkg::STEP_FIRST : step_out + 1'b1;
                end
                default:
                    state_r <= ST_MEM_GO;
            endcase
        end
    end

    // display, LED and trace outputs
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            disp_code_out <= pst_pkg::DISP_BLANK;
            disp_seg_out <= '0;
            leds_all_on_out <= 1'b0;
            diag_active_out <= 1'b0;
            default_function_out <= 1'b0;
            trace_function_out <= '0;
            trace_range_out <= '0;
        end
        else
        begin
            leds_all_on_out <= (state_r == ST_SEG);
            disp_seg_out <= seg_r;
            diag_active_out <= diag_r;
            default_function_out <= (state_r == ST_INFO) && !diag_r &&
                (tmr_r == pst_pkg::TMR_W'(INFO_HOLD - 1));
            // frozen from diagnostic entry, so later selections do not leak in
            if (!diag_r)
            begin
                trace_function_out <= function_in;
                trace_range_out <= range_in;
            end
            case (state_r)
                ST_HALT:
                    disp_code_out <= (mem_sel_out == pst_pkg::PST_MEM_ROM) ?
                        pst_pkg::DISP_ZEROS : pst_pkg::DISP_AAAA;
                ST_UNCALIBRATED_MESSAGE:
                    disp_code_out <= pst_pkg::DISP_UNCALIBRATED_MESSAGE;
                ST_INFO:
                    disp_code_out <= pst_pkg::DISP_ADDR_REV;
                ST_SEG:
                    disp_code_out <= pst_pkg::DISP_SEGTEST;
                ST_TROUBLE:
                    disp_code_out <= pst_pkg::DISP_STEP;
                ST_NORMAL, ST_PGM_HI, ST_PGM_LO:
                    disp_code_out <= pst_pkg::DISP_NORMAL;
                default:
                    disp_code_out <= pst_pkg::DISP_BLANK;
            endcase
        end
    end

    property p_halt_sticks;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_r == ST_HALT) |=> (state_r == ST_HALT) && halted_out;
    endproperty
    a_halt_sticks: assert property (p_halt_sticks) else $error("halt left");

    property p_ram_after_rom;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        $changed(mem_sel_out) && (mem_sel_out == pst_pkg::PST_MEM_RAM)
            |-> $past(mem_sel_out) == pst_pkg::PST_MEM_ROM && $past(pass_s);
    endproperty
    a_ram_after_rom: assert property (p_ram_after_rom) else $error("RAM before ROM pass");

    property p_uncalibrated_message_disp;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_r == ST_UNCALIBRATED_MESSAGE) ##1 (state_r == ST_UNCALIBRATED_MESSAGE)
            |-> disp_code_out == pst_pkg::DISP_UNCALIBRATED_MESSAGE && !halted_out;
    endproperty
    a_uncalibrated_message_disp: assert property (p_uncalibrated_message_disp) else $error("uncalibrated_message display wrong");

    property p_uncalibrated_message_exit;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_r == ST_UNCALIBRATED_MESSAGE) && oth_p |=> state_r == ST_NORMAL;
    endproperty
    a_uncalibrated_message_exit: assert property (p_uncalibrated_message_exit) else $error("uncalibrated_message not left");

    property p_step_wrap;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_r == ST_TROUBLE) && ent_p && !oth_p && !pgm_p
            |=> step_out == (($past(step_out) == pst_pkg::STEP_LAST) ?
                pst_pkg::STEP_FIRST : $past(step_out) + 3'h1);
    endproperty
    a_step_wrap: assert property (p_step_wrap) else $error("step advance wrong");

    property p_diag_exit;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_r == ST_TROUBLE) && oth_p |=> (state_r == ST_NORMAL) ##1 !diag_active_out;
    endproperty
    a_diag_exit: assert property (p_diag_exit) else $error("diag not ended");

    property p_trace_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        diag_r ##1 diag_r |-> $stable(trace_function_out) && $stable(trace_range_out);
    endproperty
    a_trace_hold: assert property (p_trace_hold) else $error("function changed");

    property p_leds_seg;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state_r == ST_SEG) |=> leds_all_on_out;
    endproperty
    a_leds_seg: assert property (p_leds_seg) else $error("LEDs off in test");
endmodule // pst_top

// >>> sim/pst_mem_model.sv
// memory tester on the far side of the done/pass handshake
module pst_mem_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [1:0] sel_in,
    input wire logic [1:0] fail_sel_in,
    input wire logic [3:0] lat_in,
    output logic done_out,
    output logic pass_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic res_r = 1'b0;
    int cnt_r = 0;
    initial done_out = 1'b0;
    always @(posedge clk_in)
    begin
        if (start_in)
        begin
            cnt_r <= 1;
            res_r <= (sel_in != fail_sel_in);
        end
        else if (cnt_r != 0)
            cnt_r <= (cnt_r == lat_in + 4) ? 0 : cnt_r + 1;
        done_out <= (cnt_r >= lat_in) && (cnt_r < lat_in + 4);
    end
    // result is only valid while done is high
    assign pass_out = done_out ? res_r : ~res_r;
endmodule // pst_mem_model

// >>> sim/pst_top_tb.sv
module pst_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, done, pass, pgm, ent, oth, dv, start, leds, diag, dflt, halt;
    logic [3:0] dig, fn, tfn, lat;
    logic [2:0] rng, trng, disp, seg, step;
    logic [1:0] sel, fail_sel;
    int fail_count, n_compared, dflt_cnt;
    logic [1:0] sels[$];

    pst_top #(.SEG_DWELL(4), .INFO_HOLD(8)) DUT (.ref_clk_in(clk), .sys_rst_in(rst),
        .mem_done_in(done), .mem_pass_in(pass), .program_select_button_in(pgm),
        .enter_button_in(ent), .other_button_in(oth), .digit_in(dig), .digit_valid_in(dv),
        .function_in(fn), .range_in(rng), .mem_start_out(start), .mem_sel_out(sel),
        .disp_code_out(disp), .disp_seg_out(seg), .step_out(step), .leds_all_on_out(leds),
        .diag_active_out(diag), .default_function_out(dflt), .trace_function_out(tfn),
        .trace_range_out(trng), .halted_out(halt));
    pst_mem_model mem (.clk_in(clk), .start_in(start), .sel_in(sel), .fail_sel_in(fail_sel),
        .lat_in(lat), .done_out(done), .pass_out(pass));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (start) sels.push_back(sel);
        if (dflt) dflt_cnt++;
    end

    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // k: 0 display code, 1 segment, 2 step
    task automatic wait_on(input int k, input logic [2:0] v);
        logic [2:0] g;
        for (int i = 0; i < 400; i++)
        begin
            g = (k == 0) ? disp : (k == 1) ? seg : step;
            if (g === v) return;
            cyc(1);
        end
        fail_count++;
        $display("unexpected at %0t: got %0h expected %0h", $time, g, v);
        finish_test();
    endtask
    task automatic do_reset(input logic [1:0] f);
        fail_sel = f;
        rst = 1'b1;
        cyc(6);
        sels.delete();
        dflt_cnt = 0;
        rst = 1'b0;
    endtask
    task automatic press(input int b);
        pgm = (b == 0);
        ent = (b == 1);
        oth = (b == 2);
        cyc(3);
        {pgm, ent, oth} = 3'h0;
        cyc(3);
    endtask
    task automatic digit(input logic [3:0] d);
        dig = d;
        dv = 1'b1;
        cyc(3);
        dv = 1'b0;
        dig = ~d;
        cyc(3);
    endtask

    task automatic t_pass;
        lat = 4'h2;
        do_reset(2'h3);
        wait_on(0, pst_pkg::DISP_ADDR_REV);
        check(4'(sels.size()), 4'h3);
        check(4'(sels[0]), 4'h0);
        check(4'(sels[1]), 4'h1);
        check(4'(sels[2]), 4'h2);
        cyc(6);
        check(4'(disp), 4'(pst_pkg::DISP_ADDR_REV));
        wait_on(0, pst_pkg::DISP_NORMAL);
        cyc(2);
        check(4'(dflt_cnt), 4'h1);
        check(4'(halt), 4'h0);
        $display("power-up pass test done");
    endtask
    task automatic t_fail(input logic [1:0] f, input logic [2:0] code);
        lat = 4'h9;
        do_reset(f);
        wait_on(0, code);
        cyc(20);
        check(4'(halt), 4'(f != 2'h2));
        check(4'(sels.size()), 4'(f) + 4'h1);
        press(2);
        if (f == 2'h2)
            wait_on(0, pst_pkg::DISP_NORMAL);
        else
            check(4'(disp), 4'(code));
        $display("memory failure test done");
    endtask
    task automatic t_diag;
        lat = 4'h9;
        fn = 4'h5;
        rng = 3'h2;
        do_reset(2'h3);
        wait_on(0, pst_pkg::DISP_NORMAL);
        press(0);
        digit(4'h3);
        digit(4'h4);
        cyc(10);
        check(4'(diag), 4'h0);
        sels.delete();
        press(0);
        digit(4'h3);
        digit(4'h3);
        wait_on(0, pst_pkg::DISP_SEGTEST);
        check(4'(leds), 4'h1);
        fn = 4'hA;
        rng = 3'h6;
        for (int i = 0; i < pst_pkg::SEG_COUNT; i++)
            wait_on(1, 3'(i));
        wait_on(0, pst_pkg::DISP_STEP);
        check(4'(sels.size()), 4'h3);
        check(4'(step), 4'(pst_pkg::STEP_FIRST));
        check(tfn, 4'h5);
        check(4'(trng), 4'h2);
        for (int i = 1; i <= 4; i++)
        begin
            press(1);
            wait_on(2, 3'(i % 4 + 1));
        end
        check(4'(diag), 4'h1);
        press(2);
        wait_on(0, pst_pkg::DISP_NORMAL);
        check(4'(diag), 4'h0);
        check(4'(leds), 4'h0);
        check(tfn, 4'hA);
        check(4'(trng), 4'h6);
        $display("diagnostic program test done");
    endtask

    initial
    begin
        {rst, pgm, ent, oth, dv} = 5'h10;
        dig = 4'h0;
        fn = 4'h0;
        rng = 3'h0;
        fail_sel = 2'h3;
        lat = 4'h2;
        fail_count = 0;
        n_compared = 0;
        dflt_cnt = 0;
        t_pass();
        t_fail(2'h0, pst_pkg::DISP_ZEROS);
        t_fail(2'h1, pst_pkg::DISP_AAAA);
        t_fail(2'h2, pst_pkg::DISP_UNCALIBRATED_MESSAGE);
        t_diag();
        finish_test();
    end
endmodule // pst_top_tb
